// *** hw/lcd_serial_command_decoder.sv ***
`timescale 1ns/100ps
module lcd_serial_command_decoder (
   input wire logic clock, // core clock
   input wire logic reset_n, // async reset, active low
   input wire logic writeStrobeClk, // link clock, host write strobe
   input wire logic chipSelN, // host chip select, active low
   input wire logic readStrobeN, // host read strobe, active low
   input wire logic dataIn, // data line as seen at the pin
   output logic dataOut, // data line drive value
   output logic dataOe, // data line driven when high
   input wire logic tickLevel, // time base output, core domain
   input wire logic dogTimeout, // watchdog expiry pulse, core domain
   output logic irqN, // interrupt pin value, active low
   output logic irqOe, // interrupt pin driven when high
   output lcd_serial_command_decoder_pkg::ctrl_state_type ctrlState, // configuration
   output logic buzzerDrive, // tone outputs allowed to toggle
   output logic tickCounterClear, // one-cycle clear of tick counter
   output logic dogCounterClear // one-cycle clear of watchdog
);
   import lcd_serial_command_decoder_pkg::*;

   localparam logic [3:0] MODE_LAST = 4'(MODE_W - 1);
   localparam logic [3:0] ADDR_LAST = 4'(ADDR_W - 1);
   localparam logic [3:0] NIB_LAST = 4'(NIB_W - 1);
   localparam logic [3:0] CMD_LAST = 4'(CMD_W - 1);
   localparam logic [1:0] BIT_LAST = 2'(NIB_W - 1);

   // link domain, clocked by the write strobe
   logic linkRstN;
   parse_state_type parseState_r;
   logic [3:0] bitCnt_r;
   logic [CMD_W-1:0] shift_r;
   logic [MODE_W-1:0] mode_r;
   logic [ADDR_W-1:0] writeAddr_r;
   logic [NIB_W-1:0] nibble_r;
   logic [MODE_W-1:0] modeNow;
   logic [ADDR_W-1:0] addrNow;
   logic [CMD_W-1:0] cmdNow;
   logic [NIB_W-1:0] nibNow;
   logic postValid;
   link_event_type postWord;
   link_event_type event_r;
   logic eventToggle_r;

   // the strobe only runs inside a frame, so chip select ends it
   assign linkRstN = reset_n & ~chipSelN;

   // fields as completed by the bit on the line now
   assign modeNow = {shift_r[MODE_W-2:0], dataIn};
   assign addrNow = {shift_r[ADDR_W-2:0], dataIn};
   assign cmdNow = {shift_r[CMD_W-2:0], dataIn};
   assign nibNow = {dataIn, nibble_r[NIB_W-1:1]};

   // serial history, newest bit at the bottom
   always_ff @(posedge writeStrobeClk or negedge linkRstN) begin
      if (!linkRstN) begin
         shift_r <= '0;
      end else begin
         shift_r <= cmdNow;
      end
   end

   // word completed on this strobe
   always_comb begin
      postValid = 1'b0;
      postWord = '{kind: EV_NONE, addr: '0, payload: '0};
      unique case (parseState_r)
         ST_ADDR: begin
            if (bitCnt_r == ADDR_LAST) begin
               postValid = 1'b1;
               postWord.kind = EV_ADDR;
               postWord.addr = addrNow;
               postWord.payload = CMD_W'(mode_r);
            end
         end
         ST_DATA: begin
            if (bitCnt_r == NIB_LAST) begin
               postValid = 1'b1;
               postWord.kind = EV_WRITE;
               postWord.addr = writeAddr_r;
               postWord.payload = CMD_W'(nibNow);
            end
         end
         ST_CMD: begin
            if (bitCnt_r == CMD_LAST) begin
               postValid = 1'b1;
               postWord.kind = EV_CMD;
               postWord.payload = cmdNow;
            end
         end
         default: begin
         end
      endcase
   end

   // mode, address and data framing
   always_ff @(posedge writeStrobeClk or negedge linkRstN) begin
      if (!linkRstN) begin
         parseState_r <= ST_MODE;
         bitCnt_r <= 4'h0;
         mode_r <= '0;
         writeAddr_r <= '0;
         nibble_r <= '0;
      end else begin
         unique case (parseState_r)
            ST_MODE: begin
               if (bitCnt_r == MODE_LAST) begin
                  bitCnt_r <= 4'h0;
                  mode_r <= modeNow;
                  if (modeNow == MODE_READ || modeNow == MODE_WRITE) begin
                     parseState_r <= ST_ADDR;
                  end else if (modeNow == MODE_CMD) begin
                     parseState_r <= ST_CMD;
                  end else begin
                     parseState_r <= ST_IGNORE;
                  end
               end else begin
                  bitCnt_r <= bitCnt_r + 4'h1;
               end
            end
            ST_ADDR: begin
               if (bitCnt_r == ADDR_LAST) begin
                  bitCnt_r <= 4'h0;
                  writeAddr_r <= addrNow;
                  // reads need no more write strobes until a new frame
                  parseState_r <= (mode_r == MODE_WRITE) ? ST_DATA : ST_IGNORE;
               end else begin
                  bitCnt_r <= bitCnt_r + 4'h1;
               end
            end
            ST_DATA: begin
               nibble_r <= nibNow;
               if (bitCnt_r == NIB_LAST) begin
                  bitCnt_r <= 4'h0;
                  writeAddr_r <= nextNibbleAddr(writeAddr_r);
               end else begin
                  bitCnt_r <= bitCnt_r + 4'h1;
               end
            end
            ST_CMD: begin
               // stays in command mode, no new mode bits needed
               bitCnt_r <= (bitCnt_r == CMD_LAST) ? 4'h0 : bitCnt_r + 4'h1;
            end
            ST_IGNORE: begin
            end
            default: begin
               parseState_r <= ST_MODE;
            end
         endcase
      end
   end

   // held word plus toggle; not cleared by chip select so no false event
   always_ff @(posedge writeStrobeClk or negedge reset_n) begin
      if (!reset_n) begin
         event_r <= '{kind: EV_NONE, addr: '0, payload: '0};
         eventToggle_r <= 1'b0;
      end else if (postValid) begin
         event_r <= postWord;
         eventToggle_r <= ~eventToggle_r;
      end
   end

   // core domain
   logic csSync1_r, csSync2_r;
   logic rdSync1_r, rdSync2_r, rdSync3_r;
   logic wrSync1_r, wrSync2_r;
   logic togSync1_r, togSync2_r, togSeen_r;
   logic newEvent;
   logic rdFall;
   logic isCmd;
   logic [7:0] cmd8;
   logic [NIB_W-1:0] ram_r [RAM_DEPTH];
   logic readArmed_r;
   logic [ADDR_W-1:0] readAddr_r;
   logic [1:0] readBit_r;
   logic dataOut_r, dataOe_r;
   ctrl_state_type ctrl_r;
   logic tickClear_r, dogClear_r;
   logic dogFlag_r;
   logic irqN_r, irqOe_r, buzzer_r;
   logic [NIB_W-1:0] readNibble;

   // pin and cross-domain synchronisers, idle levels at reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         csSync1_r <= 1'b1;
         csSync2_r <= 1'b1;
         rdSync1_r <= 1'b1;
         rdSync2_r <= 1'b1;
         rdSync3_r <= 1'b1;
         wrSync1_r <= 1'b1;
         wrSync2_r <= 1'b1;
         togSync1_r <= 1'b0;
         togSync2_r <= 1'b0;
         togSeen_r <= 1'b0;
      end else begin
         csSync1_r <= chipSelN;
         csSync2_r <= csSync1_r;
         rdSync1_r <= readStrobeN;
         rdSync2_r <= rdSync1_r;
         rdSync3_r <= rdSync2_r;
         wrSync1_r <= writeStrobeClk;
         wrSync2_r <= wrSync1_r;
         togSync1_r <= eventToggle_r;
         togSync2_r <= togSync1_r;
         togSeen_r <= togSync2_r;
      end
   end

   // event word is stable for several strobes after the toggle flips
   assign newEvent = togSync2_r ^ togSeen_r;
   assign rdFall = rdSync3_r & ~rdSync2_r;
   assign isCmd = newEvent && event_r.kind == EV_CMD;
   assign cmd8 = event_r.payload[CMD_W-1:1];
   assign readNibble = ram_r[readAddr_r[RAM_IDX_W-1:0]];

   // display memory, data only, no reset
   always_ff @(posedge clock) begin
      if (newEvent && event_r.kind == EV_WRITE) begin
         ram_r[event_r.addr[RAM_IDX_W-1:0]] <= event_r.payload[NIB_W-1:0];
      end
   end

   // read engine; one bit per read-strobe fall, d0 first
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         readArmed_r <= 1'b0;
         readAddr_r <= '0;
         readBit_r <= 2'h0;
         dataOut_r <= 1'b0;
         dataOe_r <= 1'b0;
      end else if (csSync2_r) begin
         readArmed_r <= 1'b0;
         dataOe_r <= 1'b0;
      end else begin
         if (newEvent && event_r.kind == EV_ADDR) begin
            readArmed_r <= 1'b1;
            readAddr_r <= event_r.addr;
            readBit_r <= 2'h0;
         end else if (rdFall && readArmed_r) begin
            dataOut_r <= readNibble[readBit_r];
            dataOe_r <= 1'b1;
            readBit_r <= readBit_r + 2'h1;
            if (readBit_r == BIT_LAST) begin
               readAddr_r <= nextNibbleAddr(readAddr_r);
            end
         end
         // host takes the line back when it starts writing
         if (!wrSync2_r) begin
            dataOe_r <= 1'b0;
         end
      end
   end

   // configuration commands, unknown codes change nothing
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (isCmd) begin
         if (cmd8 == OSC_AND_BIAS_OFF_CMD) begin
            // power-down is ineffective on an external clock
            if (ctrl_r.source != SRC_EXTERNAL) begin
               ctrl_r.oscOn <= 1'b0;
               ctrl_r.biasGenOn <= 1'b0;
            end
         end else if (cmd8 == OSC_ON_CMD) begin
            ctrl_r.oscOn <= 1'b1;
         end else if (cmd8 == BIAS_GEN_OFF_CMD) begin
            ctrl_r.biasGenOn <= 1'b0;
         end else if (cmd8 == BIAS_GEN_ON_CMD) begin
            ctrl_r.biasGenOn <= 1'b1;
         end else if (cmd8 == TICK_ROUTE_OFF_CMD) begin
            ctrl_r.tickRouteOn <= 1'b0;
         end else if (cmd8 == TICK_ROUTE_ON_CMD) begin
            ctrl_r.tickRouteOn <= 1'b1;
            ctrl_r.dogRouteOn <= 1'b0;
         end else if (cmd8 == DOG_FLAG_ROUTE_OFF_CMD) begin
            ctrl_r.dogRouteOn <= 1'b0;
         end else if (cmd8 == DOG_FLAG_ROUTE_ON_CMD) begin
            ctrl_r.dogRouteOn <= 1'b1;
            ctrl_r.tickRouteOn <= 1'b0;
         end else if (cmd8 == BUZZER_OFF_CMD) begin
            ctrl_r.buzzerOn <= 1'b0;
         end else if (cmd8 == BUZZER_ON_CMD) begin
            ctrl_r.buzzerOn <= 1'b1;
         end else if (cmd8[7:4] == CLOCK_SOURCE_GROUP) begin
            if (cmd8[3:2] != 2'h0) begin
               ctrl_r.source <= clk_source_type'(cmd8[3:2]);
            end
         end else if (cmd8[7:4] == DRIVE_MODE_GROUP) begin
            if (cmd8[3:2] != COMMONS_ILLEGAL) begin
               ctrl_r.commons <= cmd8[3:2];
               ctrl_r.biasThird <= cmd8[0];
            end
         end else if (cmd8[7:5] == BUZZER_HIGH_PITCH_CMD) begin
            ctrl_r.buzzerHighPitch <= 1'b1;
         end else if (cmd8[7:5] == BUZZER_LOW_PITCH_CMD) begin
            ctrl_r.buzzerHighPitch <= 1'b0;
         end else if (cmd8[7:5] == INT_PIN_GROUP) begin
            ctrl_r.intPinOn <= cmd8[3];
         end else if (cmd8[7:5] == RATE_SELECT_CMD) begin
            ctrl_r.rate <= cmd8[2:0];
         end else if (cmd8 == TEST_MODE_CMD) begin
            ctrl_r.testMode <= 1'b1;
         end else if (cmd8 == NORMAL_MODE_CMD) begin
            ctrl_r.testMode <= 1'b0;
         end
      end
   end

   // counter clear strobes; the watchdog pattern also hits the tick one
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tickClear_r <= 1'b0;
         dogClear_r <= 1'b0;
      end else begin
         tickClear_r <= isCmd && cmd8[7:2] == TICK_COUNTER_CLEAR_CMD;
         dogClear_r <= isCmd && cmd8[7:1] == DOG_COUNTER_CLEAR_CMD;
      end
   end

   // sticky watchdog flag; a timeout in the clearing cycle wins
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dogFlag_r <= 1'b0;
      end else if (dogTimeout) begin
         dogFlag_r <= 1'b1;
      end else if (isCmd && (cmd8[7:1] == DOG_COUNTER_CLEAR_CMD ||
                             (cmd8[7:5] == INT_PIN_GROUP && !cmd8[3]))) begin
         dogFlag_r <= 1'b0;
      end
   end

   // pin-facing outputs, all registered
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irqN_r <= 1'b1;
         irqOe_r <= 1'b0;
         buzzer_r <= 1'b0;
      end else begin
         irqOe_r <= ctrl_r.intPinOn;
         irqN_r <= ctrl_r.dogRouteOn ? ~dogFlag_r : ~(ctrl_r.tickRouteOn & tickLevel);
         // tone stays low while the system oscillator is off
         buzzer_r <= ctrl_r.buzzerOn & ctrl_r.oscOn;
      end
   end

   assign dataOut = dataOut_r;
   assign dataOe = dataOe_r;
   assign irqN = irqN_r;
   assign irqOe = irqOe_r;
   assign ctrlState = ctrl_r;
   assign buzzerDrive = buzzer_r;
   assign tickCounterClear = tickClear_r;
   assign dogCounterClear = dogClear_r;

endmodule

// *** inc/lcd_serial_command_decoder_pkg.sv ***
package lcd_serial_command_decoder_pkg;

   // serial field widths and display memory size
   localparam int MODE_W = 3;
   localparam int ADDR_W = 6;
   localparam int NIB_W = 4;
   localparam int CMD_W = 9;
   localparam int RAM_DEPTH = 32;
   localparam int RAM_IDX_W = 5;

   // mode identifiers, first bit in the msb
   localparam logic [2:0] MODE_READ = 3'h6;
   localparam logic [2:0] MODE_WRITE = 3'h5;
   localparam logic [2:0] MODE_CMD = 3'h4;

   // full command codes, the ninth bit dropped
   localparam logic [7:0] OSC_AND_BIAS_OFF_CMD = 8'h00;
   localparam logic [7:0] OSC_ON_CMD = 8'h01;
   localparam logic [7:0] BIAS_GEN_OFF_CMD = 8'h02;
   localparam logic [7:0] BIAS_GEN_ON_CMD = 8'h03;
   localparam logic [7:0] TICK_ROUTE_OFF_CMD = 8'h04;
   localparam logic [7:0] DOG_FLAG_ROUTE_OFF_CMD = 8'h05;
   localparam logic [7:0] TICK_ROUTE_ON_CMD = 8'h06;
   localparam logic [7:0] DOG_FLAG_ROUTE_ON_CMD = 8'h07;
   localparam logic [7:0] BUZZER_OFF_CMD = 8'h08;
   localparam logic [7:0] BUZZER_ON_CMD = 8'h09;
   localparam logic [7:0] TEST_MODE_CMD = 8'hE0;
   localparam logic [7:0] NORMAL_MODE_CMD = 8'hE3;

   // command prefixes, compared against the top bits only, and the illegal commons code for bits 3:2
   localparam logic [5:0] TICK_COUNTER_CLEAR_CMD = 6'h03;
   localparam logic [6:0] DOG_COUNTER_CLEAR_CMD = 7'h07;
   localparam logic [3:0] CLOCK_SOURCE_GROUP = 4'h1;
   localparam logic [3:0] DRIVE_MODE_GROUP = 4'h2;
   localparam logic [2:0] BUZZER_HIGH_PITCH_CMD = 3'h2;
   localparam logic [2:0] BUZZER_LOW_PITCH_CMD = 3'h3;
   localparam logic [2:0] INT_PIN_GROUP = 3'h4;
   localparam logic [2:0] RATE_SELECT_CMD = 3'h5;
   localparam logic [1:0] COMMONS_ILLEGAL = 2'h3;

   typedef enum logic [1:0] {
      SRC_NONE = 2'h0,
      SRC_CRYSTAL = 2'h1,
      SRC_INTERNAL = 2'h2,
      SRC_EXTERNAL = 2'h3
   } clk_source_type;

   typedef enum logic [1:0] {
      EV_NONE = 2'h0,
      EV_ADDR = 2'h1,
      EV_WRITE = 2'h2,
      EV_CMD = 2'h3
   } event_kind_type;

   // gray codes along mode -> addr -> data
   typedef enum logic [2:0] {
      ST_MODE = 3'h0,
      ST_ADDR = 3'h1,
      ST_DATA = 3'h3,
      ST_CMD = 3'h2,
      ST_IGNORE = 3'h6
   } parse_state_type;

   typedef struct packed {
      event_kind_type kind;
      logic [ADDR_W-1:0] addr;
      logic [CMD_W-1:0] payload;
   } link_event_type;

   typedef struct packed {
      logic oscOn;
      logic biasGenOn;
      logic buzzerOn;
      logic buzzerHighPitch;
      clk_source_type source;
      logic biasThird;
      logic [1:0] commons;
      logic [2:0] rate;
      logic tickRouteOn;
      logic dogRouteOn;
      logic intPinOn;
      logic testMode;
   } ctrl_state_type;

   // power-on configuration
   localparam logic [2:0] RATE_RESET = 3'h7;
   localparam logic [1:0] COMMONS_RESET = 2'h0;
   localparam ctrl_state_type CTRL_RESET = '{
      oscOn: 1'b0, biasGenOn: 1'b0, buzzerOn: 1'b0, buzzerHighPitch: 1'b0,
      source: SRC_INTERNAL, biasThird: 1'b0, commons: COMMONS_RESET,
      rate: RATE_RESET, tickRouteOn: 1'b0, dogRouteOn: 1'b0,
      intPinOn: 1'b0, testMode: 1'b0};

   // next nibble location, wrapping inside the implemented range
   function automatic logic [ADDR_W-1:0] nextNibbleAddr(input logic [ADDR_W-1:0] a);
      logic [RAM_IDX_W-1:0] low;
      low = a[RAM_IDX_W-1:0] + 5'h01;
      return {1'b0, low};
   endfunction

endpackage

// *** verif/lcd_serial_command_decoder_asserts.sv ***
`timescale 1ns/100ps
module lcd_serial_command_decoder_asserts (
   input wire logic clock, // core clock
   input wire logic reset_n, // async reset
   input wire logic writeStrobeClk, // link clock
   input wire logic chipSelN, // select
   input wire logic readStrobeN, // read strobe
   input wire logic dataIn, // data pin
   input wire logic dataOut, // drive value
   input wire logic dataOe, // drive enable
   input wire logic tickLevel, // time base
   input wire logic dogTimeout, // expiry
   input wire logic irqN, // irq value
   input wire logic irqOe, // irq enable
   input wire lcd_serial_command_decoder_pkg::ctrl_state_type ctrlState, // config
   input wire logic buzzerDrive, // tone gate
   input wire logic tickCounterClear, // tick clear
   input wire logic dogCounterClear // dog clear
);
   import lcd_serial_command_decoder_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   // first edge after release shows the power-on set
   a_reset_config: assert property ($rose(reset_n) |-> ctrlState == CTRL_RESET && irqN && !irqOe)
      else $error("config wrong after reset");
   a_clear_overlap: assert property (dogCounterClear |-> tickCounterClear)
      else $error("dog clear without tick clear");
   a_clear_pulse: assert property (tickCounterClear |=> !tickCounterClear)
      else $error("tick clear longer than a cycle");
   a_buzzer_gate: assert property (!ctrlState.oscOn [*2] |-> !buzzerDrive)
      else $error("tone active with oscillator off");
   a_irq_float: assert property (!ctrlState.intPinOn [*2] |-> !irqOe)
      else $error("irq pin driven while disabled");
   a_irq_tick: assert property ((ctrlState.tickRouteOn && !ctrlState.dogRouteOn && tickLevel) [*2] |-> !irqN)
      else $error("time base not on irq pin");
   a_dog_latch: assert property (dogTimeout && ctrlState.dogRouteOn |-> ##[1:3] !irqN)
      else $error("watchdog expiry not on irq pin");
   // the read engine only drives after a read strobe fall
   a_read_cause: assert property ($rose(dataOe) |-> !$past(readStrobeN, 2))
      else $error("data driven without read strobe");
   a_oe_release: assert property (chipSelN [*5] |-> !dataOe)
      else $error("data still driven after deselect");
   a_source_legal: assert property (ctrlState.source != SRC_NONE)
      else $error("clock source code illegal");
   a_commons_legal: assert property (ctrlState.commons != COMMONS_ILLEGAL)
      else $error("commons code illegal");
endmodule

// *** verif/host_link_model.sv ***
`timescale 1ns/100ps
module host_link_model (
   output logic chipSelN, // select, active low
   output logic writeStrobeClk, // write strobe, idle high
   output logic readStrobeN, // read strobe, active low
   output logic dataIn, // resolved data line
   input wire logic dataOut, // device drive value
   input wire logic dataOe // device drive enable
);
   logic hostBit = 1'b0;
   logic hostOe = 1'b0;
   logic lineLast = 1'b0;

   // no pull on the line: a floating wire shows the inverse of its last level
   assign dataIn = hostOe ? hostBit : (dataOe ? dataOut : ~lineLast);
   always @(hostOe or hostBit or dataOe or dataOut) begin
      if (hostOe || dataOe)
         lineLast = hostOe ? hostBit : dataOut;
   end

   initial begin
      chipSelN = 1'b1;
      writeStrobeClk = 1'b1;
      readStrobeN = 1'b1;
   end

   // every frame starts from a fresh mode id
   task automatic frameOpen;
      chipSelN = 1'b0;
      #60;
   endtask
   // deselect long enough for the core to see it
   task automatic frameClose;
      #30 hostOe = 1'b0;
      chipSelN = 1'b1;
      #60;
   endtask
   // bits msb first, data set on the fall, taken on the rise
   task automatic sendBits(input logic [8:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         writeStrobeClk = 1'b0;
         hostBit = v[i];
         hostOe = 1'b1;
         #24 writeStrobeClk = 1'b1;
         #24;
      end
   endtask
   // d0 first, sampled after each rise
   task automatic readNib(output logic [3:0] d);
      hostOe = 1'b0;
      #100;
      for (int i = 0; i < 4; i++) begin
         readStrobeN = 1'b0;
         #50 readStrobeN = 1'b1;
         d[i] = dataIn;
         #40;
      end
   endtask
endmodule

// *** verif/tb_lcd_serial_command_decoder.sv ***
`timescale 1ns/100ps
module tb_lcd_serial_command_decoder;
   import lcd_serial_command_decoder_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic tickLevel = 1'b0;
   logic dogTimeout = 1'b0;
   logic writeStrobeClk, chipSelN, readStrobeN, dataIn;
   logic dataOut, dataOe, irqN, irqOe, buzzerDrive, tickCounterClear, dogCounterClear;
   ctrl_state_type ctrlState;
   int fail_count = 0;
   int num_checks = 0;
   int tickPulses = 0;
   int dogPulses = 0;
   int tickBase, dogBase;
   logic [3:0] r0, r1;

   always #5 clock = ~clock;

   lcd_serial_command_decoder uut (.clock(clock), .reset_n(reset_n), .writeStrobeClk(writeStrobeClk),
      .chipSelN(chipSelN), .readStrobeN(readStrobeN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .tickLevel(tickLevel), .dogTimeout(dogTimeout), .irqN(irqN), .irqOe(irqOe), .ctrlState(ctrlState),
      .buzzerDrive(buzzerDrive), .tickCounterClear(tickCounterClear), .dogCounterClear(dogCounterClear));
   host_link_model host (.chipSelN(chipSelN), .writeStrobeClk(writeStrobeClk), .readStrobeN(readStrobeN),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));

   // count clear pulses, each should last one cycle
   always @(posedge clock) begin
      tickPulses <= tickPulses + int'(tickCounterClear === 1'b1);
      dogPulses <= dogPulses + int'(dogCounterClear === 1'b1);
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ninth bit set on purpose, it must be ignored
   task automatic cmd(input logic [7:0] code);
      host.sendBits({code, 1'b1}, 9);
      repeat (10) @(posedge clock);
      // step off the edge so checks and pin changes never race it
      #1;
   endtask
   task automatic nibW(input logic [3:0] v);
      host.sendBits({5'h00, v[0], v[1], v[2], v[3]}, 4);
   endtask
   task automatic start(input logic [2:0] mode, input logic [5:0] a);
      host.frameOpen();
      host.sendBits({mode, a}, 9);
   endtask
   task automatic pulseCore(ref logic s);
      @(posedge clock);
      #1 s = 1'b1;
      @(posedge clock);
      #1 s = 1'b0;
      repeat (5) @(posedge clock);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #300000;
      fail_count++;
      end_sim();
   end

   initial begin
      repeat (3) @(posedge clock);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge clock);
      check("reset config", CTRL_RESET, ctrlState);
      check("irq oe", 16'h0, irqOe);
      // one mode id, then a stream of commands
      host.frameOpen();
      host.sendBits({6'h00, MODE_CMD}, 3);
      cmd(OSC_ON_CMD);
      check("osc", 16'h1, ctrlState.oscOn);
      cmd(BIAS_GEN_ON_CMD);
      check("bias gen", 16'h1, ctrlState.biasGenOn);
      cmd(BUZZER_ON_CMD);
      check("buzzer", 16'h1, buzzerDrive);
      cmd(8'h40);
      check("pitch", 16'h1, ctrlState.buzzerHighPitch);
      cmd(8'h7F);
      check("pitch low", 16'h0, ctrlState.buzzerHighPitch);
      cmd(8'h29);
      check("drive mode", 16'h5, {ctrlState.commons, ctrlState.biasThird});
      cmd(8'h2C);
      check("commons kept", 16'h2, ctrlState.commons);
      cmd(8'hA3);
      check("rate", 16'h3, ctrlState.rate);
      cmd(8'h1C);
      check("source ext", 16'h3, ctrlState.source);
      // power-down has no effect on an external clock
      cmd(OSC_AND_BIAS_OFF_CMD);
      check("sys off ignored", 16'h3, {ctrlState.oscOn, ctrlState.biasGenOn});
      cmd(BIAS_GEN_OFF_CMD);
      check("bias gen off", 16'h0, ctrlState.biasGenOn);
      cmd(8'h10);
      check("source kept", 16'h3, ctrlState.source);
      cmd(8'h14);
      check("source xtal", 16'h1, ctrlState.source);
      cmd(OSC_AND_BIAS_OFF_CMD);
      check("sys off", 16'h0, {ctrlState.oscOn, ctrlState.biasGenOn, buzzerDrive});
      cmd(NORMAL_MODE_CMD);
      check("normal", 16'h0, ctrlState.testMode);
      tickBase = tickPulses;
      dogBase = dogPulses;
      cmd(8'h0D);
      cmd(8'h0E);
      check("tick clears", 16'h2, 16'(tickPulses - tickBase));
      check("dog clears", 16'h1, 16'(dogPulses - dogBase));
      // interrupt pin: time base, then latched watchdog flag
      cmd(8'h88);
      check("irq on", 16'h1, irqOe);
      tickLevel = 1'b1;
      cmd(TICK_ROUTE_ON_CMD);
      check("irq tick", 16'h0, irqN);
      cmd(DOG_FLAG_ROUTE_ON_CMD);
      check("irq dog idle", 16'h1, irqN);
      pulseCore(dogTimeout);
      check("irq dog held", 16'h0, irqN);
      cmd(8'h0E);
      check("irq dog clr", 16'h1, irqN);
      cmd(DOG_FLAG_ROUTE_OFF_CMD);
      check("dog route off", 16'h0, ctrlState.dogRouteOn);
      cmd(TICK_ROUTE_ON_CMD);
      check("irq tick again", 16'h0, irqN);
      cmd(TICK_ROUTE_OFF_CMD);
      check("irq tick off", 16'h1, irqN);
      cmd(8'h80);
      check("irq off", 16'h0, irqOe);
      host.frameClose();
      // unknown mode id: the rest of the frame is ignored
      host.frameOpen();
      host.sendBits({6'h00, 3'h7}, 3);
      cmd(OSC_ON_CMD);
      host.frameClose();
      check("bad mode", 16'h0, ctrlState.oscOn);
      // successive write across the top of the range
      start(MODE_WRITE, 6'h1F);
      nibW(4'hA);
      nibW(4'h5);
      host.frameClose();
      start(MODE_READ, 6'h1F);
      host.readNib(r0);
      host.readNib(r1);
      host.frameClose();
      check("read 31", 16'hA, r0);
      check("read 0", 16'h5, r1);
      // read-modify-write on two locations
      start(MODE_WRITE, 6'h1F);
      host.readNib(r0);
      nibW(4'h3);
      host.readNib(r1);
      nibW(4'hC);
      host.frameClose();
      check("rmw old 31", 16'hA, r0);
      check("rmw old 0", 16'h5, r1);
      // a partial nibble cut by deselect is dropped
      start(MODE_WRITE, 6'h00);
      host.sendBits(9'h000, 2);
      host.frameClose();
      start(MODE_READ, 6'h1F);
      host.readNib(r0);
      host.readNib(r1);
      host.frameClose();
      check("rmw new 31", 16'h3, r0);
      check("rmw new 0", 16'hC, r1);
      end_sim();
   end
endmodule

bind lcd_serial_command_decoder lcd_serial_command_decoder_asserts chk (.clock(clock), .reset_n(reset_n),
   .writeStrobeClk(writeStrobeClk), .chipSelN(chipSelN), .readStrobeN(readStrobeN), .dataIn(dataIn),
   .dataOut(dataOut), .dataOe(dataOe), .tickLevel(tickLevel), .dogTimeout(dogTimeout), .irqN(irqN),
   .irqOe(irqOe), .ctrlState(ctrlState), .buzzerDrive(buzzerDrive), .tickCounterClear(tickCounterClear),
   .dogCounterClear(dogCounterClear));
